// ===== hdl/cps_pkg.sv
// package: register map, field positions and state types for the command/status control block
package cps_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_COMMAND_ADDRESS = 16'hffdb;
	localparam logic [15:0] OFS_PORT_CONTROL_STATUS = 16'hffdc;
	localparam logic [7:0] RST_COMMAND_ADDRESS = 8'h00;
	localparam logic [7:0] RST_PORT_CONTROL_STATUS = 8'h00;
	// control/status field positions
	localparam int BIT_RX_HOLDING_FULL = 7;
	localparam int BIT_RX_FULL_IRQ_EN = 6;
	localparam int BIT_TX_HOLDING_EMPTY = 5;
	localparam int BIT_TX_EMPTY_IRQ_EN = 4;
	localparam int BIT_RESERVED = 3;
	localparam int BIT_CODEC_SELECT_HI = 2;
	localparam int BIT_CODEC_SELECT_LO = 1;
	localparam int BIT_CODEC_RESET_CTL = 0;
	// address byte fields
	localparam int BIT_MULTI_RW = 7;
	localparam int BIT_SINGLE_RW = 5;
	localparam int INDEX_W = 7;
	localparam logic [1:0] CODEC_SELECT_PRIMARY = 2'h0;
	localparam logic [3:0] MULTI_ADDR_SLOT = 4'h1;
	localparam logic [3:0] MULTI_DATA_SLOT = 4'h2;
	// interrupt source index
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;

	typedef struct packed {
		logic rx_holding_full;
		logic rx_full_irq_en;
		logic tx_holding_empty;
		logic tx_empty_irq_en;
		logic [1:0] codec_select;
		logic codec_reset_ctl;
		logic [7:0] codec_command_address;
		logic [7:0] rdata;
	} cps_state_t;

	typedef struct packed {
		logic [1:0] pend;
	} cps_pend_t;
endpackage

// ===== hdl/cps_irq_if.sv
// interface: interrupt set/clear events and pending bits between control and pending logic
interface cps_irq_if;
	logic [1:0] set_evt;
	logic clear;
	logic [1:0] pend;

	modport ctl
	(
		output set_evt,
		output clear,
		input pend
	);
	modport pnd
	(
		input set_evt,
		input clear,
		output pend
	);
endinterface

// ===== hdl/cps_irq_pend.sv
// module: pending interrupt latches, set by enabled events, cleared by a vector write
module cps_irq_pend
(
	input wire logic mclk,
	input wire logic rst,
	cps_irq_if.pnd irq
);
	cps_pkg::cps_pend_t st;
	cps_pkg::cps_pend_t next_st;

	// a set arriving with the clear keeps the latch pending
	always_comb
	begin
		next_st = st;
		if (irq.clear)
		begin
			next_st.pend = 2'h0;
		end
		next_st.pend = next_st.pend | irq.set_evt;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign irq.pend = st.pend;

	AST_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
		irq.set_evt[0] |=> irq.pend[0])
		else $error("pending bit lost its set event");
endmodule // cps_irq_pend

// ===== hdl/cps_ctl.sv
// module: codec port command/status control, status flags, codec select, reset and address byte
module cps_ctl
#(
	parameter int ADDR_W = cps_pkg::ADDR_W
)
(
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// events from the neighbouring data and vector registers
	input wire logic rx_data_read,
	input wire logic tx_data_write,
	input wire logic vector_write,
	// events from the slot framing
	input wire logic rx_capture,
	input wire logic tx_sent,
	input wire logic rx_index_valid,
	input wire logic [6:0] rx_index,
	// port mode
	input wire logic single_slot_codec_mode,
	input wire logic i2s_mode,
	// outputs to framing and pins
	output logic [15:0] cmd_slot_word,
	output logic cmd_is_read,
	output logic cmd_secondary,
	output logic [3:0] cmd_addr_slot,
	output logic [3:0] cmd_data_slot,
	output logic codec_reset_out_n,
	output logic irq_req
);
	// the map decodes a 16-bit address; a narrower bus cannot reach it
	if (ADDR_W < 16)
	begin : g_chk
		$error("cps_ctl: ADDR_W below 16 cannot reach the register map");
	end

	cps_pkg::cps_state_t st;
	cps_pkg::cps_state_t next_st;
	cps_irq_if irq_bus();

	// decode one register offset, used for both strobes
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
		hit = (a[15:0] == ofs) && ((ADDR_W == 16) || (a >> 16) == '0);
	endfunction

	// control/status byte as software reads it; reserved bit forced low
	function automatic logic [7:0] ctl_byte(input cps_pkg::cps_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[cps_pkg::BIT_RX_HOLDING_FULL] = s.rx_holding_full;
		b[cps_pkg::BIT_RX_FULL_IRQ_EN] = s.rx_full_irq_en;
		b[cps_pkg::BIT_TX_HOLDING_EMPTY] = s.tx_holding_empty;
		b[cps_pkg::BIT_TX_EMPTY_IRQ_EN] = s.tx_empty_irq_en;
		b[cps_pkg::BIT_RESERVED] = 1'b0;
		b[cps_pkg::BIT_CODEC_SELECT_HI:cps_pkg::BIT_CODEC_SELECT_LO] = s.codec_select;
		b[cps_pkg::BIT_CODEC_RESET_CTL] = s.codec_reset_ctl;
		ctl_byte = b;
	endfunction

	logic wr_ctl;
	logic wr_adr;
	logic rd_ctl;
	logic rd_adr;

	// strobe decode
	assign wr_ctl = reg_wr && hit(reg_addr, cps_pkg::OFS_PORT_CONTROL_STATUS);
	assign wr_adr = reg_wr && hit(reg_addr, cps_pkg::OFS_COMMAND_ADDRESS);
	assign rd_ctl = reg_rd && hit(reg_addr, cps_pkg::OFS_PORT_CONTROL_STATUS);
	assign rd_adr = reg_rd && hit(reg_addr, cps_pkg::OFS_COMMAND_ADDRESS);

	// next state: software writes first, hardware events after so a set beats a clear
	always_comb
	begin
		next_st = st;
		if (wr_ctl)
		begin
			next_st.rx_full_irq_en = reg_wdata[cps_pkg::BIT_RX_FULL_IRQ_EN];
			next_st.tx_empty_irq_en = reg_wdata[cps_pkg::BIT_TX_EMPTY_IRQ_EN];
			next_st.codec_select = reg_wdata[cps_pkg::BIT_CODEC_SELECT_HI:cps_pkg::BIT_CODEC_SELECT_LO];
			next_st.codec_reset_ctl = reg_wdata[cps_pkg::BIT_CODEC_RESET_CTL];
		end
		if (wr_adr)
		begin
			next_st.codec_command_address = reg_wdata;
		end
		// status flags are read only; only hardware events move them
		if (rx_data_read)
		begin
			next_st.rx_holding_full = 1'b0;
		end
		if (rx_capture)
		begin
			next_st.rx_holding_full = 1'b1;
		end
		if (tx_data_write)
		begin
			next_st.tx_holding_empty = 1'b0;
		end
		if (tx_sent)
		begin
			next_st.tx_holding_empty = 1'b1;
		end
		// returned index wins over a software write in the same cycle
		if (rx_index_valid)
		begin
			next_st.codec_command_address[cps_pkg::INDEX_W-1:0] = rx_index;
		end
		// read data stand in the cycle after the strobe only
		if (rd_ctl)
		begin
			next_st.rdata = ctl_byte(st);
		end
		else if (rd_adr)
		begin
			next_st.rdata = st.codec_command_address;
		end
		else
		begin
			next_st.rdata = 8'h00;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// interrupt events: an enabled flag-setting event becomes pending
	assign irq_bus.set_evt[cps_pkg::IRQ_RX] = rx_capture && st.rx_full_irq_en;
	assign irq_bus.set_evt[cps_pkg::IRQ_TX] = tx_sent && st.tx_empty_irq_en;
	// vector write clears only the pending bits, never the status flags
	assign irq_bus.clear = vector_write;

	cps_irq_pend u_pend
	(
		.mclk(mclk),
		.rst(rst),
		.irq(irq_bus.pnd)
	);

	assign irq_req = |irq_bus.pend;
	assign reg_rdata = st.rdata;

	// whole address byte leads the 16-bit command slot; software laid out the fields
	assign cmd_slot_word = {st.codec_command_address, 8'h00};
	// read flag sits at the top bit in multi-slot, at slot bit 13 in single-slot
	assign cmd_is_read = single_slot_codec_mode ?
		st.codec_command_address[cps_pkg::BIT_SINGLE_RW] :
		st.codec_command_address[cps_pkg::BIT_MULTI_RW];
	// secondary codec only exists on the multi-slot link
	assign cmd_secondary = !single_slot_codec_mode &&
		(st.codec_select != cps_pkg::CODEC_SELECT_PRIMARY);
	// multi-slot uses separate address and data slots
	assign cmd_addr_slot = cps_pkg::MULTI_ADDR_SLOT;
	assign cmd_data_slot = cps_pkg::MULTI_DATA_SLOT;
	// driven straight from the bit in every mode; the I2S codec simply ignores it
	assign codec_reset_out_n = st.codec_reset_ctl;

	// checks; the competing event is excluded where set-wins ordering would otherwise interfere
	AST_RX_SET: assert property (@(posedge mclk) disable iff (rst)
		rx_capture |=> st.rx_holding_full)
		else $error("receive-full not set after capture");

	AST_RX_CLR: assert property (@(posedge mclk) disable iff (rst)
		(rx_data_read && !rx_capture) |=> !st.rx_holding_full)
		else $error("receive-full not cleared by data read");

	AST_RX_RO: assert property (@(posedge mclk) disable iff (rst)
		(wr_ctl && !rx_capture && !rx_data_read) |=> st.rx_holding_full == $past(st.rx_holding_full))
		else $error("software write moved receive-full");

	AST_RX_VEC: assert property (@(posedge mclk) disable iff (rst)
		(vector_write && !rx_capture && !rx_data_read) |=>
		(!irq_bus.pend[cps_pkg::IRQ_RX] && st.rx_holding_full == $past(st.rx_holding_full)))
		else $error("vector write mishandled receive interrupt or flag");

	// a disabled event may keep an older pending bit but never raise a new one
	AST_RX_EN: assert property (@(posedge mclk) disable iff (rst)
		(rx_capture && !st.rx_full_irq_en) |=>
		(!irq_bus.pend[cps_pkg::IRQ_RX] || $past(irq_bus.pend[cps_pkg::IRQ_RX])))
		else $error("receive interrupt raised while disabled");

	AST_RX_IRQ: assert property (@(posedge mclk) disable iff (rst)
		(rx_capture && st.rx_full_irq_en) |=> (irq_req && irq_bus.pend[cps_pkg::IRQ_RX]))
		else $error("enabled receive event did not raise interrupt");

	AST_TX_SET: assert property (@(posedge mclk) disable iff (rst)
		tx_sent |=> st.tx_holding_empty)
		else $error("transmit-empty not set after send");

	AST_TX_RD: assert property (@(posedge mclk) disable iff (rst)
		rd_ctl |=> reg_rdata[cps_pkg::BIT_TX_HOLDING_EMPTY] == $past(st.tx_holding_empty))
		else $error("transmit-empty read back wrong");

	AST_TX_CLR: assert property (@(posedge mclk) disable iff (rst)
		(tx_data_write && !tx_sent) |=> !st.tx_holding_empty)
		else $error("transmit-empty not cleared by data write");

	AST_TX_RO: assert property (@(posedge mclk) disable iff (rst)
		(wr_ctl && !tx_sent && !tx_data_write) |=> st.tx_holding_empty == $past(st.tx_holding_empty))
		else $error("software write moved transmit-empty");

	AST_TX_VEC: assert property (@(posedge mclk) disable iff (rst)
		(vector_write && !tx_sent && !tx_data_write) |=>
		(!irq_bus.pend[cps_pkg::IRQ_TX] && st.tx_holding_empty == $past(st.tx_holding_empty)))
		else $error("vector write mishandled transmit interrupt or flag");

	AST_TX_EN: assert property (@(posedge mclk) disable iff (rst)
		(tx_sent && !st.tx_empty_irq_en) |=>
		(!irq_bus.pend[cps_pkg::IRQ_TX] || $past(irq_bus.pend[cps_pkg::IRQ_TX])))
		else $error("transmit interrupt raised while disabled");

	AST_TX_IRQ: assert property (@(posedge mclk) disable iff (rst)
		(tx_sent && st.tx_empty_irq_en) |=> (irq_req && irq_bus.pend[cps_pkg::IRQ_TX]))
		else $error("enabled transmit event did not raise interrupt");

	AST_EN_RD: assert property (@(posedge mclk) disable iff (rst)
		rd_ctl |=> (reg_rdata[cps_pkg::BIT_RX_FULL_IRQ_EN] == $past(st.rx_full_irq_en) &&
		reg_rdata[cps_pkg::BIT_TX_EMPTY_IRQ_EN] == $past(st.tx_empty_irq_en)))
		else $error("interrupt enables read back wrong");

	// only a vector write may drop a pending request
	AST_IRQ_HOLD: assert property (@(posedge mclk) disable iff (rst)
		(irq_req && !vector_write) |=> irq_req)
		else $error("pending interrupt dropped without vector write");

	AST_SEL: assert property (@(posedge mclk) disable iff (rst)
		wr_ctl |=> cmd_secondary == (!single_slot_codec_mode &&
		$past(reg_wdata[cps_pkg::BIT_CODEC_SELECT_HI:cps_pkg::BIT_CODEC_SELECT_LO]) != cps_pkg::CODEC_SELECT_PRIMARY))
		else $error("codec select not applied");

	AST_CODEC_RESET_CTL: assert property (@(posedge mclk) disable iff (rst)
		(wr_ctl && !rst) |=> codec_reset_out_n == $past(reg_wdata[cps_pkg::BIT_CODEC_RESET_CTL]))
		else $error("codec reset output does not follow written bit");

	// the pin is not gated by the I2S modes
	AST_I2S: assert property (@(posedge mclk) disable iff (rst)
		(wr_ctl && i2s_mode) |=> codec_reset_out_n == $past(reg_wdata[cps_pkg::BIT_CODEC_RESET_CTL]))
		else $error("codec reset output gated in I2S mode");

	AST_RSVD: assert property (@(posedge mclk) disable iff (rst)
		rd_ctl |=> (reg_rdata[cps_pkg::BIT_RESERVED] == 1'b0 &&
		reg_rdata[cps_pkg::BIT_RX_HOLDING_FULL] == $past(st.rx_holding_full)))
		else $error("control/status read returned wrong bits");

	AST_SLOT: assert property (@(posedge mclk) disable iff (rst)
		(wr_adr && !rx_index_valid) |=> cmd_slot_word == {$past(reg_wdata), 8'h00})
		else $error("command slot does not carry the address byte");

	AST_MULTI_RW: assert property (@(posedge mclk) disable iff (rst)
		!single_slot_codec_mode |-> cmd_is_read == cmd_slot_word[15])
		else $error("multi-slot read flag not at the top bit");

	AST_SINGLE_RW: assert property (@(posedge mclk) disable iff (rst)
		single_slot_codec_mode |-> cmd_is_read == cmd_slot_word[13])
		else $error("single-slot read flag not at slot bit 13");

	AST_ADR: assert property (@(posedge mclk) disable iff (rst)
		(wr_adr && !rx_index_valid) |=> st.codec_command_address == $past(reg_wdata))
		else $error("address byte not stored");

	AST_ADR_RD: assert property (@(posedge mclk) disable iff (rst)
		rd_adr |=> reg_rdata == $past(st.codec_command_address))
		else $error("address byte read back wrong");

	AST_IDX: assert property (@(posedge mclk) disable iff (rst)
		rx_index_valid |=> st.codec_command_address[6:0] == $past(rx_index))
		else $error("returned index not loaded");
endmodule // cps_ctl

// ===== test/cps_codec_model.sv
// partner: codec far side, answers one command slot with status events
module cps_codec_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic go,
	input wire logic [3:0] lag,
	input wire logic [6:0] ret_idx,
	input wire logic cmd_is_read,
	input wire logic [15:0] cmd_slot_word,
	output logic rx_capture,
	output logic tx_sent,
	output logic rx_index_valid,
	output logic [6:0] rx_index
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy;
	logic rd;
	logic [3:0] cnt;
	// wait out the slot lag, then answer once; idle index toggles so no stale value passes
	always_ff @(posedge mclk)
	begin
		rx_capture <= 1'b0;
		tx_sent <= 1'b0;
		rx_index_valid <= 1'b0;
		rx_index <= ~rx_index;
		if (rst)
		begin
			busy <= 1'b0;
			rd <= 1'b0;
			cnt <= 4'h0;
			rx_index <= 7'h00;
		end
		else if (go)
		begin
			busy <= 1'b1;
			rd <= cmd_is_read;
			cnt <= lag;
		end
		else if (busy && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (busy)
		begin
			busy <= 1'b0;
			rx_capture <= rd;
			rx_index_valid <= rd;
			tx_sent <= ~rd;
			if (rd)
				rx_index <= ret_idx;
		end
	end
endmodule // cps_codec_model

// ===== test/tb_codec_port_command_status_ctl.sv
// testbench: register, status event and command slot checks for the command/status block
module tb_codec_port_command_status_ctl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] CTL = cps_pkg::OFS_PORT_CONTROL_STATUS;
	localparam logic [15:0] ADR = cps_pkg::OFS_COMMAND_ADDRESS;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] ev = 3'h0;
	logic single = 1'b0;
	logic i2s = 1'b0;
	logic go = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [6:0] ret_idx = 7'h00;
	logic [7:0] reg_rdata;
	logic [15:0] cmd_slot_word;
	logic [3:0] cmd_addr_slot, cmd_data_slot;
	logic cmd_is_read, cmd_secondary, codec_reset_out_n, irq_req, rx_capture, tx_sent, rx_index_valid;
	logic [6:0] rx_index;
	int num_errors = 0;
	int checked = 0;
	// free-running clock
	always #20 mclk = ~mclk;
	cps_ctl u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data_read(ev[0]), .tx_data_write(ev[1]),
		.vector_write(ev[2]), .rx_capture(rx_capture), .tx_sent(tx_sent), .rx_index_valid(rx_index_valid),
		.rx_index(rx_index), .single_slot_codec_mode(single), .i2s_mode(i2s), .cmd_slot_word(cmd_slot_word),
		.cmd_is_read(cmd_is_read), .cmd_secondary(cmd_secondary), .cmd_addr_slot(cmd_addr_slot),
		.cmd_data_slot(cmd_data_slot), .codec_reset_out_n(codec_reset_out_n), .irq_req(irq_req));
	cps_codec_model u_codec (.mclk(mclk), .rst(rst), .go(go), .lag(lag), .ret_idx(ret_idx),
		.cmd_is_read(cmd_is_read), .cmd_slot_word(cmd_slot_word), .rx_capture(rx_capture),
		.tx_sent(tx_sent), .rx_index_valid(rx_index_valid), .rx_index(rx_index));
	// compare and count
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", 16'(reg_rdata), 16'(exp));
	endtask
	// bit 0 receive read, 1 transmit write, 2 vector write
	task automatic pulse(input int k);
		@(posedge mclk);
		ev[k] <= 1'b1;
		@(posedge mclk);
		ev[k] <= 1'b0;
		#1;
	endtask
	// lag bounds the wait: the model answers lag+1 edges after go
	task automatic xact(input logic [3:0] l, input logic [6:0] idx);
		@(posedge mclk);
		go <= 1'b1;
		lag <= l;
		ret_idx <= idx;
		@(posedge mclk);
		go <= 1'b0;
		repeat (int'(l) + 4) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog, far beyond the roughly 120 cycles the sequence needs
	initial
	begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		give_verdict();
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(CTL, 8'h00);
		rd(ADR, 8'h00);
		chk("reset_out_n", 16'(codec_reset_out_n), 16'h0000);
		wr(CTL, 8'hff);
		rd(CTL, 8'h57);
		chk("reset_out_n", 16'(codec_reset_out_n), 16'h0001);
		@(posedge mclk);
		i2s <= 1'b1;
		wr(CTL, 8'h00);
		chk("reset_out_n", 16'(codec_reset_out_n), 16'h0000);
		@(posedge mclk);
		i2s <= 1'b0;
		for (int s = 0; s < 4; s++)
		begin
			wr(CTL, 8'(s * 2 + 1));
			chk("secondary", 16'(cmd_secondary), 16'(s != 0));
		end
		wr(ADR, 8'h85);
		rd(ADR, 8'h85);
		chk("slot_word", cmd_slot_word, 16'h8500);
		chk("is_read", 16'(cmd_is_read), 16'h0001);
		chk("addr_slot", 16'(cmd_addr_slot), 16'h0001);
		chk("data_slot", 16'(cmd_data_slot), 16'h0002);
		@(posedge mclk);
		single <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("is_read", 16'(cmd_is_read), 16'h0000);
		wr(ADR, 8'h20);
		chk("is_read", 16'(cmd_is_read), 16'h0001);
		chk("secondary", 16'(cmd_secondary), 16'h0000);
		@(posedge mclk);
		single <= 1'b0;
		// write transaction, slow codec, transmit interrupt enabled
		wr(CTL, 8'h11);
		wr(ADR, 8'h12);
		xact(4'h9, 7'h00);
		rd(CTL, 8'h31);
		chk("irq", 16'(irq_req), 16'h0001);
		pulse(2);
		chk("irq", 16'(irq_req), 16'h0000);
		rd(CTL, 8'h31);
		pulse(1);
		rd(CTL, 8'h11);
		// read transaction, prompt codec, index comes back changed
		wr(CTL, 8'h41);
		wr(ADR, 8'h85);
		xact(4'h0, 7'h3c);
		rd(CTL, 8'hc1);
		chk("irq", 16'(irq_req), 16'h0001);
		rd(ADR, 8'hbc);
		pulse(2);
		chk("irq", 16'(irq_req), 16'h0000);
		rd(CTL, 8'hc1);
		pulse(0);
		rd(CTL, 8'h41);
		// flag sets with its enable off, but no interrupt, not even once enabled later
		wr(CTL, 8'h01);
		wr(ADR, 8'h12);
		xact(4'h2, 7'h00);
		rd(CTL, 8'h21);
		chk("irq", 16'(irq_req), 16'h0000);
		wr(CTL, 8'h11);
		chk("irq", 16'(irq_req), 16'h0000);
		wr(16'hffdd, 8'hff);
		rd(16'hffdd, 8'h00);
		rd(ADR, 8'h12);
		// second reset in mid-run must drop the reset pin and all registers again
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk("reset_out_n", 16'(codec_reset_out_n), 16'h0000);
		chk("irq", 16'(irq_req), 16'h0000);
		rd(CTL, 8'h00);
		rd(ADR, 8'h00);
		give_verdict();
	end
endmodule // tb_codec_port_command_status_ctl
